// File: tlbx_pkg.sv
// Constants for the two-way 32-line address translator.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
package tlbx_pkg;
    // Register byte addresses; entry words sit at number * 4
    localparam logic [9:0] TLBX_ENT_TOP  = 10'h1FC;
    localparam logic [9:0] TLBX_CFG_ADR  = 10'h200;
    localparam logic [9:0] TLBX_LRU_ADR  = 10'h204;
    localparam logic [9:0] TLBX_PC1_ADR  = 10'h208;
    localparam logic [9:0] TLBX_CHA_ADR  = 10'h20C;
    localparam logic [9:0] TLBX_TRAP_ADR = 10'h210;
    // Entry word 0 fields
    localparam int TLBX_VIRTUAL_PAGE_TAG_MSB = 31;
    localparam int TLBX_VIRTUAL_PAGE_TAG_LSB = 15;
    localparam int TLBX_VALID    = 14;
    localparam int TLBX_TID_MSB  = 13;
    localparam int TLBX_TID_LSB  = 6;
    localparam int TLBX_SUP_MSB  = 5;
    localparam int TLBX_SUP_LSB  = 3;
    localparam int TLBX_USR_MSB  = 2;
    localparam int TLBX_USR_LSB  = 0;
    // Position inside a three-bit permission group
    localparam int TLBX_P_READ   = 2;
    localparam int TLBX_P_WRITE  = 1;
    localparam int TLBX_P_EXEC   = 0;
    // Entry word 1 fields
    localparam int TLBX_RPN_MSB  = 31;
    localparam int TLBX_RPN_LSB  = 10;
    localparam int TLBX_UB_MSB   = 9;
    localparam int TLBX_UB_LSB   = 8;
    localparam int TLBX_IO       = 7;
    localparam int TLBX_USAGE    = 0;
    // Configuration register fields
    localparam int TLBX_PS_MSB   = 9;
    localparam int TLBX_PS_LSB   = 8;
    localparam int TLBX_PID_MSB  = 7;
    localparam logic [31:0] TLBX_CFG_RST = 32'h0000_0000;
    // Address split for 1 kb pages; larger pages shift by page size
    localparam int TLBX_LINE_LSB = 10;
    localparam logic [16:0] TLBX_TAG_ALL  = 17'h1FFFF;
    localparam logic [31:0] TLBX_OFF_1K   = 32'h0000_0400;
    localparam logic [31:0] TLBX_OFF_INC  = 32'h0000_0010;
    // Trap vectors
    localparam logic [7:0] TLBX_VEC_MISS = 8'h08;
    localparam logic [7:0] TLBX_VEC_IPV  = 8'h0C;
    localparam logic [7:0] TLBX_VEC_DPV  = 8'h0D;
endpackage : tlbx_pkg

// File: tlbx_translator.sv
// Address translator: 64-entry two-way buffer, lookup, protection, traps.
// Assumes requests synchronous to clk_i; software fills entries over
// classic Wishbone. One request per cycle, answer one cycle later.
`timescale 1ns/100ps
module tlbx_translator (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Processor status
    input  wire logic        phys_instr_bit_i,
    input  wire logic        rom_space_select_i,
    input  wire logic        phys_data_bit_i,
    // Access request
    input  wire logic        req_valid_i,
    input  wire logic [31:0] req_vaddr_i,
    input  wire logic        req_insn_i,
    input  wire logic        req_store_i,
    input  wire logic        req_user_i,
    input  wire logic        req_idmem_i,
    input  wire logic        physical_override_bit_i,
    input  wire logic        req_incr16_i,
    // Access answer
    output logic             rsp_valid_o,
    output logic [31:0]      rsp_paddr_o,
    output logic             rsp_io_space_o,
    output logic             rsp_translated_o,
    output logic [1:0]       translated_user_outputs_o,
    output logic             access_invalidate_o,
    output logic             trap_o,
    output logic [7:0]       trap_vector_o
);
    logic [31:0] tlb_w0_r [0:63];
    logic [31:0] tlb_w1_r [0:63];
    logic [31:0] usage_r;
    logic [31:0] cfg_r;
    logic [6:0]  lru_rec_r;
    logic [31:0] pc1_r;
    logic [31:0] cha_r;
    logic [7:0]  last_vec_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;

    logic [1:0]  ps;
    logic [31:0] line_sh;
    logic [4:0]  line;
    logic [16:0] tag_mask;
    logic [31:0] off_mask;
    logic [7:0]  pnum;
    logic        xlate;
    logic [1:0]  hit;
    logic        any_hit;
    logic        hs;
    logic [31:0] hw0;
    logic [31:0] hw1;
    logic [2:0]  grp;
    logic        allowed;
    logic [31:0] offs;
    logic [31:0] paddr;
    logic        ok;
    logic        miss;
    logic        viol;
    logic [7:0]  miss_vec;

    // Lookup address split
    assign ps       = cfg_r[tlbx_pkg::TLBX_PS_MSB:tlbx_pkg::TLBX_PS_LSB];
    assign line_sh  = req_vaddr_i >> (tlbx_pkg::TLBX_LINE_LSB + int'(ps));
    assign line     = line_sh[4:0];
    assign tag_mask = tlbx_pkg::TLBX_TAG_ALL << ps;
    assign off_mask = (tlbx_pkg::TLBX_OFF_1K << ps) - 32'h0000_0001;
    assign pnum     = req_user_i ? cfg_r[tlbx_pkg::TLBX_PID_MSB:0]
                                 : 8'h00;

    // Which accesses go through the buffer
    always_comb begin
        if (req_insn_i) begin
            xlate = !phys_instr_bit_i && !rom_space_select_i;
        end else if (req_user_i) begin
            xlate = req_idmem_i && !phys_data_bit_i;
        end else begin
            xlate = req_idmem_i && !physical_override_bit_i
                    && !phys_data_bit_i;
        end
    end

    // Per-set tag, owner and valid compare
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_set
            logic [31:0] w0;
            logic [16:0] vt;
            assign w0 = tlb_w0_r[{1'(s), line}];
            assign vt = w0[tlbx_pkg::TLBX_VIRTUAL_PAGE_TAG_MSB:tlbx_pkg::TLBX_VIRTUAL_PAGE_TAG_LSB];
            assign hit[s] =
                (((vt ^ req_vaddr_i[31:15]) & tag_mask) == 17'h00000)
                && (w0[tlbx_pkg::TLBX_TID_MSB:tlbx_pkg::TLBX_TID_LSB]
                    == pnum)
                && w0[tlbx_pkg::TLBX_VALID];
        end
    endgenerate

    // Set 0 wins when software lets both qualify
    assign any_hit = |hit;
    assign hs      = !hit[0];
    assign hw0     = tlb_w0_r[{hs, line}];
    assign hw1     = tlb_w1_r[{hs, line}];

    // Permission group by mode, bit by access type
    assign grp = req_user_i
        ? hw0[tlbx_pkg::TLBX_USR_MSB:tlbx_pkg::TLBX_USR_LSB]
        : hw0[tlbx_pkg::TLBX_SUP_MSB:tlbx_pkg::TLBX_SUP_LSB];
    assign allowed = req_insn_i  ? grp[tlbx_pkg::TLBX_P_EXEC]
                   : req_store_i ? grp[tlbx_pkg::TLBX_P_WRITE]
                   : grp[tlbx_pkg::TLBX_P_READ];

    // Frame bits above the offset, offset from the address, plus 16 when req_incr16_i
    assign offs  = req_incr16_i ? req_vaddr_i + tlbx_pkg::TLBX_OFF_INC
                                : req_vaddr_i;
    assign paddr = ({hw1[tlbx_pkg::TLBX_RPN_MSB:tlbx_pkg::TLBX_RPN_LSB],
                     10'h000} & ~off_mask) | (offs & off_mask);

    assign ok       = req_valid_i && xlate && any_hit && allowed;
    assign miss     = req_valid_i && xlate && !any_hit;
    assign viol     = req_valid_i && xlate && any_hit && !allowed;
    assign miss_vec = tlbx_pkg::TLBX_VEC_MISS
                    + {6'h00, !req_user_i, !req_insn_i};

    // Answer to the pipeline and channel
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_o               <= 1'b0;
            rsp_paddr_o               <= 32'h0000_0000;
            rsp_io_space_o            <= 1'b0;
            rsp_translated_o          <= 1'b0;
            translated_user_outputs_o <= 2'h0;
            access_invalidate_o       <= 1'b0;
            trap_o                    <= 1'b0;
            trap_vector_o             <= 8'h00;
        end else begin
            rsp_valid_o      <= req_valid_i;
            rsp_translated_o <= req_valid_i && xlate;
            rsp_paddr_o      <= xlate ? paddr : req_vaddr_i;
            rsp_io_space_o   <= ok && hw1[tlbx_pkg::TLBX_IO];
            translated_user_outputs_o <= ok
                ? hw1[tlbx_pkg::TLBX_UB_MSB:tlbx_pkg::TLBX_UB_LSB]
                : 2'h0;
            access_invalidate_o <= miss || viol;
            trap_o              <= miss || viol;
            if (miss) begin
                trap_vector_o <= miss_vec;
            end else if (viol) begin
                trap_vector_o <= req_insn_i ? tlbx_pkg::TLBX_VEC_IPV
                                            : tlbx_pkg::TLBX_VEC_DPV;
            end else begin
                trap_vector_o <= 8'h00;
            end
        end
    end

    // Usage per line; a permitted hit makes the other set the victim
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            usage_r <= 32'h0000_0000;
        end else begin
            // Software write first, so a hit on the same line overrides it
            if (cyc_i && stb_i && we_i && ack_r && sel_i[0]
                && adr_i <= tlbx_pkg::TLBX_ENT_TOP && adr_i[2]) begin
                usage_r[adr_i[7:3]] <= dat_i[tlbx_pkg::TLBX_USAGE];
            end
            if (ok) begin
                usage_r[line] <= !hs;
            end
        end
    end

    // Reload hint and faulting address; only hardware writes these
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lru_rec_r  <= 7'h00;
            pc1_r      <= 32'h0000_0000;
            cha_r      <= 32'h0000_0000;
            last_vec_r <= 8'h00;
        end else begin
            if (miss) begin
                lru_rec_r <= {usage_r[line], line, 1'b0};
            end
            if ((miss || viol) && req_insn_i) begin
                pc1_r <= req_vaddr_i;
            end
            if ((miss || viol) && !req_insn_i) begin
                cha_r <= req_vaddr_i;
            end
            if (miss) begin
                last_vec_r <= miss_vec;
            end else if (viol) begin
                last_vec_r <= req_insn_i ? tlbx_pkg::TLBX_VEC_IPV
                                         : tlbx_pkg::TLBX_VEC_DPV;
            end
        end
    end

    // Bus: one wait state, ack held one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= cyc_i && stb_i && !ack_r;
            dat_r <= rd_nxt;
        end
    end
    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // Entry words by number {set, line, word}; usage read per line
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (adr_i <= tlbx_pkg::TLBX_ENT_TOP) begin
            if (adr_i[2]) begin
                rd_nxt = tlb_w1_r[adr_i[8:3]];
                rd_nxt[tlbx_pkg::TLBX_USAGE] = usage_r[adr_i[7:3]];
            end else begin
                rd_nxt = tlb_w0_r[adr_i[8:3]];
            end
        end else begin
            case (adr_i)
                tlbx_pkg::TLBX_CFG_ADR:  rd_nxt = cfg_r;
                tlbx_pkg::TLBX_LRU_ADR:  rd_nxt = {25'h0000000, lru_rec_r};
                tlbx_pkg::TLBX_PC1_ADR:  rd_nxt = pc1_r;
                tlbx_pkg::TLBX_CHA_ADR:  rd_nxt = cha_r;
                tlbx_pkg::TLBX_TRAP_ADR: rd_nxt = {24'h000000, last_vec_r};
                default:                 rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Byte-lane merge for writes
    logic [31:0] bmask;
    logic        wr;
    // Writes land at the edge where the master samples ack high
    assign wr    = cyc_i && stb_i && we_i && ack_r;
    assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                    {8{sel_i[0]}}};

    // Only software writes entries
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 64; i++) begin
                tlb_w0_r[i] <= 32'h0000_0000;
                tlb_w1_r[i] <= 32'h0000_0000;
            end
        end else if (wr && adr_i <= tlbx_pkg::TLBX_ENT_TOP) begin
            if (adr_i[2]) begin
                tlb_w1_r[adr_i[8:3]] <= (tlb_w1_r[adr_i[8:3]] & ~bmask)
                                      | (dat_i & bmask);
            end else begin
                tlb_w0_r[adr_i[8:3]] <= (tlb_w0_r[adr_i[8:3]] & ~bmask)
                                      | (dat_i & bmask);
            end
        end
    end

    // Configuration: page size and process number
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= tlbx_pkg::TLBX_CFG_RST;
        end else if (wr && adr_i == tlbx_pkg::TLBX_CFG_ADR) begin
            cfg_r <= (cfg_r & ~bmask) | (dat_i & bmask);
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_miss_req;
        req_valid_i && xlate && !any_hit;
    endsequence
    sequence s_trap_out;
        trap_o && access_invalidate_o && !rsp_io_space_o;
    endsequence
    sequence s_ok_req;
        req_valid_i && xlate && any_hit && allowed;
    endsequence

    a_bypass_pass: assert property (
        req_valid_i && !xlate |=> rsp_valid_o && !trap_o
            && rsp_paddr_o == $past(req_vaddr_i)
            && translated_user_outputs_o == 2'h0)
        else $error("bypass changed address or trapped");
    a_miss_trap: assert property (
        s_miss_req |=> s_trap_out ##0 (trap_vector_o >= 8'h08
            && trap_vector_o <= 8'h0B))
        else $error("miss without miss trap");
    a_miss_lru: assert property (
        s_miss_req |=> lru_rec_r[0] == 1'b0
            && lru_rec_r[5:1] == $past(line))
        else $error("lru hint not loaded on miss");
    a_fetch_fault: assert property (
        s_miss_req ##0 req_insn_i |=> pc1_r == $past(req_vaddr_i))
        else $error("fetch fault address lost");
    a_prot_vector: assert property (
        viol |=> s_trap_out ##0 (trap_vector_o == 8'h0C
            || trap_vector_o == 8'h0D))
        else $error("violation without protection trap");
    a_user_low: assert property (
        rsp_valid_o && !rsp_translated_o |-> translated_user_outputs_o
            == 2'h0)
        else $error("user outputs high without translation");
    a_usage_flip: assert property (
        ok |=> usage_r[$past(line)] != $past(hs))
        else $error("usage not moved to other set");
    a_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held two cycles");
    a_sup_zero: assert property (
        ok && !req_user_i
            |-> hw0[tlbx_pkg::TLBX_TID_MSB:tlbx_pkg::TLBX_TID_LSB] == 8'h00)
        else $error("supervisor hit on nonzero owner");
    a_user_bits: assert property (
        s_ok_req |=> translated_user_outputs_o
            == $past(hw1[tlbx_pkg::TLBX_UB_MSB:tlbx_pkg::TLBX_UB_LSB]))
        else $error("user outputs not taken from entry");
    a_io_space: assert property (
        s_ok_req |=> rsp_io_space_o == $past(hw1[tlbx_pkg::TLBX_IO]))
        else $error("io space bit not taken from entry");
    a_ok_clean: assert property (
        s_ok_req |=> rsp_translated_o && !trap_o && !access_invalidate_o)
        else $error("permitted access trapped");
    a_data_fault: assert property (
        s_miss_req ##0 !req_insn_i |=> cha_r == $past(req_vaddr_i))
        else $error("data fault address lost");
    a_prot_insn: assert property (
        viol && req_insn_i |=> trap_vector_o == tlbx_pkg::TLBX_VEC_IPV)
        else $error("wrong instruction violation vector");
    a_offset_kept: assert property (
        ok && !req_incr16_i |=> rsp_paddr_o[9:0] == $past(req_vaddr_i[9:0]))
        else $error("page offset altered");
endmodule : tlbx_translator

// File: tlbx_core_model.sv
// Processor-side request source facing the address translator.
// Assumes the bench pulses go_i for one cycle per request.
`timescale 1ns/100ps
module tlbx_core_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Bench command: insn, store, user, override, incr16, address
    input  wire logic        go_i,
    input  wire logic [36:0] cmd_i,
    // Request towards the translator
    output logic             req_valid_o,
    output logic [36:0]      req_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_valid_o <= 1'b0;
            req_o       <= '0;
        end else if (go_i) begin
            req_valid_o <= 1'b1;
            req_o       <= cmd_i;
        end else begin
            // Released fields must not keep their last value
            req_valid_o <= 1'b0;
            req_o       <= ~req_o;
        end
    end
endmodule : tlbx_core_model

// File: tlbx_translator_tb.sv
// Self-checking bench for the address translator.
// Assumes entries are filled over Wishbone, requests via the core model.
`timescale 1ns/100ps
module tlbx_translator_tb;
    localparam logic [4:0] UL = 5'h04, US = 5'h0C, UF = 5'h14;
    localparam logic [4:0] UFI = 5'h15, SL = 5'h00, SF = 5'h10;
    localparam logic [4:0] SLO = 5'h02;
    logic        clk_i, rst_i, cyc, stb, we, ack, go, rv;
    logic        pib, rss, pdb, o_io, o_xl, o_inv, o_tr, e_io, o_rv;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat, rd, o_pa, va, va2, va3;
    logic [36:0] cmd, rq;
    logic [1:0]  o_ub, ub;
    logic [7:0]  o_vec, current_process_number;
    logic [21:0] fr, fr2;
    logic [16:0] tg;
    logic [4:0]  ln;
    int          error_cnt, n_compared, ps;

    tlbx_core_model i_tlbx_core_model (.clk_i(clk_i), .rst_i(rst_i),
        .go_i(go), .cmd_i(cmd), .req_valid_o(rv), .req_o(rq));
    tlbx_translator i_tlbx_translator (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .phys_instr_bit_i(pib), .rom_space_select_i(rss),
        .phys_data_bit_i(pdb), .req_valid_i(rv), .req_vaddr_i(rq[31:0]),
        .req_insn_i(rq[36]), .req_store_i(rq[35]), .req_user_i(rq[34]),
        .req_idmem_i(~rq[36]), .physical_override_bit_i(rq[33]),
        .req_incr16_i(rq[32]), .rsp_valid_o(o_rv), .rsp_paddr_o(o_pa),
        .rsp_io_space_o(o_io), .rsp_translated_o(o_xl),
        .translated_user_outputs_o(o_ub), .access_invalidate_o(o_inv),
        .trap_o(o_tr), .trap_vector_o(o_vec));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    // Classic single cycle; data taken at the edge that sees ack
    task automatic wb(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rqst(input logic [4:0] k, input logic [31:0] a);
        @(posedge clk_i);
        go  <= 1'b1;
        cmd <= {k, a};
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            #1;
        end while (o_rv !== 1'b1);
    endtask : rqst

    task automatic hit(input logic [31:0] e, input logic i,
                       input logic [1:0] u);
        chk(o_pa, e);
        chk({o_tr, o_inv, o_vec}, 10'h000);
        chk({o_io, o_ub, o_xl}, {i, u, 1'b1});
    endtask : hit

    task automatic trp(input logic [7:0] v);
        chk({o_tr, o_inv, o_vec, o_ub, o_io}, {2'b11, v, 3'b000});
    endtask : trp

    task automatic byp(input logic [31:0] a);
        chk(o_pa, a);
        chk({o_tr, o_xl, o_ub, o_io}, 5'h00);
    endtask : byp

    function automatic logic [31:0] xpa(input logic [21:0] f,
                                        input logic [31:0] a,
                                        input logic i);
        logic [31:0] m;
        m = (32'h0000_0400 << ps) - 32'h0000_0001;
        return ({f, 10'h000} & ~m) | ((a + (i ? 32'h10 : 32'h0)) & m);
    endfunction : xpa

    function automatic logic [9:0] ea(input logic s, input logic w);
        return {1'b0, s, ln, w, 2'b00};
    endfunction : ea

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {rst_i, cyc, stb, we, go, pib, rss, pdb} = 8'h80;
        adr = 10'h000;
        wdat = 32'h0;
        cmd = 37'h0;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'hF5A35555));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, tlbx_pkg::TLBX_CFG_ADR, 32'h0);
        chk(rd, 32'h0);
        wb(1, 10'h3F0, 32'hFFFF_FFFF);
        wb(0, 10'h3F0, 32'h0);
        chk(rd, 32'h0);
        for (ps = 0; ps < 4; ps++) begin
            va  = $urandom();
            current_process_number = 8'($urandom()) | 8'h01;
            ub  = 2'($urandom());
            e_io = ps[0];
            fr  = (22'($urandom()) >> ps) << ps;
            fr2 = fr ^ 22'h200000;
            tg  = (va[31:15] >> ps) << ps;
            ln  = 5'(va >> (10 + ps));
            va2 = va ^ 32'h8000_0000;
            va3 = va ^ 32'h4000_0000;
            wb(1, tlbx_pkg::TLBX_CFG_ADR, {22'h0, 2'(ps), current_process_number});
            wb(0, tlbx_pkg::TLBX_CFG_ADR, 32'h0);
            chk(rd, {22'h0, 2'(ps), current_process_number});
            // Distinct tags keep a single qualifying entry per line
            wb(1, ea(0, 0), {tg ^ 17'h10000, 1'b1, 8'h00, 6'h30});
            wb(1, ea(0, 1), {fr2, 10'h000});
            wb(1, ea(1, 0), {tg, 1'b1, current_process_number, 6'h05});
            wb(1, ea(1, 1), {fr, ub, e_io, 7'h00});
            wb(0, ea(1, 0), 32'h0);
            chk(rd, {tg, 1'b1, current_process_number, 6'h05});
            rqst(UL, va);
            hit(xpa(fr, va, 1'b0), e_io, ub);
            rqst(UFI, va);
            hit(xpa(fr, va, 1'b1), e_io, ub);
            rqst(US, va);
            trp(8'h0D);
            rqst(SL, va);
            trp(8'h0B);
            wb(0, tlbx_pkg::TLBX_LRU_ADR, 32'h0);
            chk(rd, {25'h0, 1'b0, ln, 1'b0});
            wb(0, tlbx_pkg::TLBX_CHA_ADR, 32'h0);
            chk(rd, va);
            rqst(SL, va2);
            hit(xpa(fr2, va2, 1'b0), 1'b0, 2'b00);
            rqst(SF, va2);
            trp(8'h0C);
            rqst(UF, va2);
            trp(8'h08);
            wb(0, tlbx_pkg::TLBX_LRU_ADR, 32'h0);
            chk(rd, {25'h0, 1'b1, ln, 1'b0});
            wb(0, tlbx_pkg::TLBX_PC1_ADR, 32'h0);
            chk(rd, va2);
            rqst(SF, va3);
            trp(8'h0A);
            rqst(UL, va3);
            trp(8'h09);
            @(posedge clk_i);
            pdb <= 1'b1;
            rqst(UL, va);
            byp(va);
            rqst(SL, va);
            byp(va);
            @(posedge clk_i);
            pdb <= 1'b0;
            rqst(SLO, va);
            byp(va);
            @(posedge clk_i);
            pib <= 1'b1;
            rqst(UF, va);
            byp(va);
            @(posedge clk_i);
            pib <= 1'b0;
            rss <= 1'b1;
            rqst(UFI, va);
            byp(va);
            @(posedge clk_i);
            rss <= 1'b0;
            wb(1, ea(1, 0), {tg, 1'b0, current_process_number, 6'h05});
            rqst(UL, va);
            trp(8'h09);
        end
        wb(0, tlbx_pkg::TLBX_TRAP_ADR, 32'h0);
        chk(rd, 32'h9);
        end_of_test();
    end
endmodule : tlbx_translator_tb
